// ---- core/tdm_route.sv ----
// Purpose: routes decoded receiver audio and aux bits as tdm8 to one of four serial outputs
// Assumes: frame words arrive on the link clock, qualified by a frame strobe at slot 0
// Notes: serial bits change on the rising link clock edge; the far end samples each a full bit later
//
// Overview of operation
// - clock select zero uses recovered clocks
// - clock select one uses generator three clocks
// - one-hot select code routes to output 0..3
// - select zero disables, outputs stay normal use
// - slots 0,4 hold 24-bit audio plus zeros
// - slots 1,5 hold parity,validity,user,status bits
// - slot 2 holds compression and audio type
// - slot 7 block start; slots 3,6 zero
`timescale 1ns/10ps
module tdm_route
	import tdm_route_pkg::*;
(
	// clocks and reset
	input  wire logic                    ref_clk_i,
	input  wire logic                    rst_n_i,
	input  wire logic                    link_clk_i,
	// axi4-lite slave
	input  wire logic                    s_awvalid,
	output logic                         s_awready,
	input  wire logic [3:0]              s_awaddr,
	input  wire logic                    s_wvalid,
	output logic                         s_wready,
	input  wire logic [31:0]             s_wdata,
	input  wire logic [3:0]              s_wstrb,
	output logic                         s_bvalid,
	input  wire logic                    s_bready,
	output logic [1:0]                   s_bresp,
	input  wire logic                    s_arvalid,
	output logic                         s_arready,
	input  wire logic [3:0]              s_araddr,
	output logic                         s_rvalid,
	input  wire logic                    s_rready,
	output logic [31:0]                  s_rdata,
	output logic [1:0]                   s_rresp,
	// receiver side, link domain
	input  wire tdm_route_pkg::rx_frame_t rx_frame_i,
	input  wire logic                    rx_frame_start_i,
	input  wire logic                    rec_bclk_i,
	input  wire logic                    rec_fclk_i,
	input  wire logic                    gen3_bclk_i,
	input  wire logic                    gen3_fclk_i,
	// serial port side
	input  wire logic [PORTS-1:0]        port_sdata_i,
	input  wire logic [PORTS-1:0]        port_bclk_i,
	input  wire logic [PORTS-1:0]        port_fclk_i,
	output logic [PORTS-1:0]             serial_data_output_pin_o,
	output logic [PORTS-1:0]             output_bit_clock_pin_o,
	output logic [PORTS-1:0]             output_frame_clock_pin_o,
	output logic [PORTS-1:0]             tdm_route_active_o
);
	logic [15:0]             ctrl_r;
	logic                    aw_held_r, w_held_r;
	logic [3:0]              awaddr_r;
	logic [31:0]             wdata_r;
	logic [3:0]              wstrb_r;
	logic [PORTS-1:0]        onehot;
	logic [PORTS-1:0]        sel_l_r;
	logic                    clk_l_r;
	logic [PORTS:0]          cfg_r;
	logic                    req_tgl_r, ack_s1_r, ack_r;
	logic                    req_s1_l_r, req_l_r, seen_l_r;
	logic [PORTS-1:0]        act_r;
	logic [SLOTS*SLOT_BITS-1:0] shift_r;
	logic                    tdm_bit_r;
	logic                    bclk_sel, fclk_sel;

	// write channel: address and data taken in either order, one at a time
	assign s_awready = !aw_held_r && !s_bvalid;
	assign s_wready  = !w_held_r && !s_bvalid;
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= 4'h0;
			wdata_r   <= 32'h0;
			wstrb_r   <= 4'h0;
			s_bvalid  <= 1'b0;
			s_bresp   <= AXI_OKAY;
			ctrl_r    <= CTRL_RESET;
		end
		else if (s_bvalid)
		begin
			if (s_bready)
				s_bvalid <= 1'b0;
		end
		else
		begin
			if (s_awvalid && s_awready)
			begin
				aw_held_r <= 1'b1;
				awaddr_r  <= s_awaddr;
			end
			if (s_wvalid && s_wready)
			begin
				w_held_r <= 1'b1;
				wdata_r  <= s_wdata;
				wstrb_r  <= s_wstrb;
			end
			if (aw_held_r && w_held_r)
			begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				s_bvalid  <= 1'b1;
				s_bresp   <= (awaddr_r == CTRL_OFFSET) ? AXI_OKAY : AXI_SLVERR;
				// only bits 4:0 are implemented; reserved bits hold zero
				if (awaddr_r == CTRL_OFFSET && wstrb_r[0])
					ctrl_r <= {11'h000, wdata_r[4:0]};
			end
		end
	end

	// read channel: one-cycle answer after address taken
	assign s_arready = !s_rvalid;
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s_rvalid <= 1'b0;
			s_rdata  <= 32'h0;
			s_rresp  <= AXI_OKAY;
		end
		else if (s_rvalid)
		begin
			if (s_rready)
				s_rvalid <= 1'b0;
		end
		else if (s_arvalid)
		begin
			s_rvalid <= 1'b1;
			s_rresp  <= AXI_OKAY;
			case (s_araddr)
				CTRL_OFFSET:   s_rdata <= {16'h0000, ctrl_r};
				STATUS_OFFSET: s_rdata <= {28'h0, act_r};
				default:
				begin
					s_rdata <= 32'h0;
					s_rresp <= AXI_SLVERR;
				end
			endcase
		end
	end

	// one-hot decode; anything else, zero included, is disabled
	always_comb
	begin
		case (ctrl_r[SEL_LSB +: PORTS])
			4'h1, 4'h2, 4'h4, 4'h8: onehot = ctrl_r[SEL_LSB +: PORTS];
			default:                onehot = 4'h0;
		endcase
	end

	// config handed over by toggle; the word holds still until the link side acknowledges,
	// so a route change can never show up two-hot on the pins
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cfg_r     <= '0;
			req_tgl_r <= 1'b0;
			act_r     <= '0;
		end
		else if (req_tgl_r == ack_r)
		begin
			act_r <= cfg_r[PORTS-1:0];
			if (cfg_r != {ctrl_r[CLKSEL_BIT], onehot})
			begin
				cfg_r     <= {ctrl_r[CLKSEL_BIT], onehot};
				req_tgl_r <= ~req_tgl_r;
			end
		end
	end

	// acknowledge back into the register domain
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ack_s1_r <= 1'b0;
			ack_r    <= 1'b0;
		end
		else
		begin
			ack_s1_r <= seen_l_r;
			ack_r    <= ack_s1_r;
		end
	end

	// link side takes the held word once the request toggle has settled
	always_ff @(posedge link_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			req_s1_l_r <= 1'b0;
			req_l_r    <= 1'b0;
			seen_l_r   <= 1'b0;
			sel_l_r    <= '0;
			clk_l_r    <= 1'b0;
		end
		else
		begin
			req_s1_l_r <= req_tgl_r;
			req_l_r    <= req_s1_l_r;
			if (req_l_r != seen_l_r)
			begin
				seen_l_r <= req_l_r;
				sel_l_r  <= cfg_r[PORTS-1:0];
				clk_l_r  <= cfg_r[PORTS];
			end
		end
	end
	assign tdm_route_active_o = act_r;

	// tdm8 frame builder, msb first; loaded at frame start
	always_ff @(posedge link_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			shift_r   <= '0;
			tdm_bit_r <= 1'b0;
		end
		else if (rx_frame_start_i)
		begin
			shift_r <= {
				rx_frame_i.left.audio, 8'h00,
				20'h00000, rx_frame_i.left.parity, rx_frame_i.left.validity,
				rx_frame_i.left.user, rx_frame_i.left.chan_status, 8'h00,
				22'h000000, rx_frame_i.compr_type, rx_frame_i.audio_type, 8'h00,
				32'h00000000,
				rx_frame_i.right.audio, 8'h00,
				20'h00000, rx_frame_i.right.parity, rx_frame_i.right.validity,
				rx_frame_i.right.user, rx_frame_i.right.chan_status, 8'h00,
				32'h00000000,
				23'h000000, rx_frame_i.block_start, 8'h00};
			tdm_bit_r <= rx_frame_i.left.audio[23];
		end
		else
		begin
			shift_r   <= {shift_r[SLOTS*SLOT_BITS-2:0], 1'b0};
			tdm_bit_r <= shift_r[SLOTS*SLOT_BITS-2];
		end
	end

	// clock source mux; generator three assumed set up by software
	assign bclk_sel = clk_l_r ? gen3_bclk_i : rec_bclk_i;
	assign fclk_sel = clk_l_r ? gen3_fclk_i : rec_fclk_i;

	// per-port output mux; unselected ports keep their normal signals
	for (genvar p = 0; p < PORTS; p++)
	begin : g_port
		assign serial_data_output_pin_o[p] = sel_l_r[p] ? tdm_bit_r : port_sdata_i[p];
		assign output_bit_clock_pin_o[p]   = sel_l_r[p] ? bclk_sel  : port_bclk_i[p];
		assign output_frame_clock_pin_o[p] = sel_l_r[p] ? fclk_sel  : port_fclk_i[p];
	end

	// checks
	a_ctrl_reset_zero: assert property (@(posedge ref_clk_i) $rose(rst_n_i) |-> ctrl_r == 16'h0000)
		else $error("control not zero after reset");
	a_onehot_only: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$countones(ctrl_r[3:0]) == 1 |-> onehot == ctrl_r[3:0])
		else $error("one-hot select not routed");
	a_zero_disables: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		ctrl_r[3:0] == 4'h0 |-> onehot == 4'h0)
		else $error("zero select not disabled");
	a_bad_code_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$countones(ctrl_r[3:0]) > 1 |-> onehot == 4'h0)
		else $error("non one-hot select routed");
	a_slot0_audio: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
		rx_frame_start_i |=> shift_r[255:232] == $past(rx_frame_i.left.audio) && shift_r[231:224] == 8'h00)
		else $error("slot 0 content wrong");
	a_slot5_aux: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
		rx_frame_start_i |=> shift_r[95:76] == 20'h0 && shift_r[75] == $past(rx_frame_i.right.parity))
		else $error("slot 5 content wrong");
	a_slot2_types: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
		rx_frame_start_i |=> shift_r[169:168] == {$past(rx_frame_i.compr_type), $past(rx_frame_i.audio_type)})
		else $error("slot 2 content wrong");
	a_slot7_start: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
		rx_frame_start_i |=> shift_r[8] == $past(rx_frame_i.block_start) && shift_r[159:128] == 32'h0
		&& shift_r[63:32] == 32'h0)
		else $error("slot 7, 3 or 6 content wrong");
	a_gen_clock: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
		clk_l_r && sel_l_r[0] |-> output_bit_clock_pin_o[0] == gen3_bclk_i)
		else $error("generator clock not routed");
	a_rec_clock: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
		!clk_l_r && sel_l_r[1] |-> output_frame_clock_pin_o[1] == rec_fclk_i)
		else $error("recovered clock not routed");
endmodule : tdm_route

// ---- inc/tdm_route_pkg.sv ----
// Purpose: constants and carriers for the receiver tdm output router
// Assumes: 32-bit axi4-lite register bus, 8-slot tdm of 32-bit slots
// Notes: register offsets are byte addresses
package tdm_route_pkg;
	localparam logic [3:0]  CTRL_OFFSET      = 4'h0;  // receiver_aux_tdm_out_ctrl
	localparam logic [3:0]  STATUS_OFFSET    = 4'h4;  // routing status readback
	localparam int          SEL_LSB          = 0;
	localparam int          CLKSEL_BIT       = 4;
	localparam logic [15:0] CTRL_RESET       = 16'h0000;
	localparam int          SLOT_BITS        = 32;
	localparam int          SLOTS            = 8;
	localparam int          PORTS            = 4;
	localparam logic [1:0]  AXI_OKAY         = 2'h0;
	localparam logic [1:0]  AXI_SLVERR       = 2'h2;

	// decoded receiver sample, left and right share one carrier
	typedef struct packed {
		logic [23:0] audio;
		logic        parity;
		logic        validity;
		logic        user;
		logic        chan_status;
	} chan_word_t;

	typedef struct packed {
		chan_word_t left;
		chan_word_t right;
		logic       compr_type;
		logic       audio_type;
		logic       block_start;
	} rx_frame_t;
endpackage : tdm_route_pkg

// ---- sim/tdm_sink.sv ----
// Purpose: downstream tdm receiver, keeps the last 256 serial bits
// Assumes: bits launched on the rising bit clock edge; that same edge samples the bit before
// Notes: no frame alignment here; the bench matches the window against rotations
`timescale 1ns/10ps
module tdm_sink
(
	// serial side
	input  wire logic         bclk_i,
	input  wire logic         sdata_i,
	// captured window
	output logic [255:0]      cap_o
);
	// receiver is a slave: it follows the bit clock that the routed port masters
	always_ff @(posedge bclk_i)
		cap_o <= {cap_o[254:0], sdata_i};
endmodule : tdm_sink

// ---- sim/testbench.sv ----
// Purpose: self-checking bench for the receiver tdm router
// Assumes: one frame every 256 link clocks, same frame repeated while it is checked
// Notes: generator source setup is outside this block and is not modelled
`timescale 1ns/10ps
module testbench;
	import tdm_route_pkg::*;
	logic ref_clk_i = 0, rst_n_i, link_clk_i, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, sink_bclk, sink_d;
	logic [3:0] awa, ara, code, eff, psd, pbc, pfc, sdo, bco, fco, act;
	logic [31:0] wd, rd, tmp;
	logic [1:0] bresp, rresp;
	logic [255:0] cap;
	logic [63:0] rnd;
	rx_frame_t rx_frame_i, next_frame;
	logic frame_start, rfc, gfc, csel;
	logic [7:0] cnt = 8'h00;
	int seed, errors, checked, idx, k;
	// generator three is locked to the receiver input, so it shares the link clock
	tdm_route tdm_route_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i),
		.s_awvalid(awv), .s_awready(awr), .s_awaddr(awa), .s_wvalid(wv), .s_wready(wr), .s_wdata(wd),
		.s_wstrb(4'hf), .s_bvalid(bv), .s_bready(br), .s_bresp(bresp), .s_arvalid(arv), .s_arready(arr),
		.s_araddr(ara), .s_rvalid(rv), .s_rready(rr), .s_rdata(rd), .s_rresp(rresp), .rx_frame_i(rx_frame_i),
		.rx_frame_start_i(frame_start), .rec_bclk_i(link_clk_i), .rec_fclk_i(rfc), .gen3_bclk_i(link_clk_i),
		.gen3_fclk_i(gfc), .port_sdata_i(psd), .port_bclk_i(pbc), .port_fclk_i(pfc),
		.serial_data_output_pin_o(sdo), .output_bit_clock_pin_o(bco), .output_frame_clock_pin_o(fco),
		.tdm_route_active_o(act));
	assign sink_d = sdo[idx];
	assign sink_bclk = bco[idx];
	tdm_sink tdm_sink_i (.bclk_i(sink_bclk), .sdata_i(sink_d), .cap_o(cap));
	// clocks: 40 ns register clock, 48 ns link clock with an odd phase
	always #20 ref_clk_i = ~ref_clk_i;
	initial
	begin
		link_clk_i = 0;
		#7;
		forever #24 link_clk_i = ~link_clk_i;
	end
	// frame source: new frame loaded one clock before its start strobe
	always @(posedge link_clk_i)
	begin
		cnt <= cnt + 8'h01;
		frame_start <= (cnt == 8'hff);
		if (cnt == 8'hfe)
			rx_frame_i <= next_frame;
	end
	// slot layout, msb of slot 0 first on the wire
	function automatic logic [255:0] frame_bits(input rx_frame_t f);
		return {f.left.audio, 8'h00, 20'h0, f.left.parity, f.left.validity, f.left.user, f.left.chan_status,
			8'h00, 22'h0, f.compr_type, f.audio_type, 8'h00, 32'h0, f.right.audio, 8'h00, 20'h0,
			f.right.parity, f.right.validity, f.right.user, f.right.chan_status, 8'h00, 32'h0,
			23'h0, f.block_start, 8'h00};
	endfunction : frame_bits
	// the sink has no frame sync, so any rotation of one frame is accepted
	function automatic logic rot_ok(input logic [255:0] c, input logic [255:0] e);
		logic [511:0] ee;
		ee = {e, e};
		for (int r = 0; r < 256; r++)
			if (ee[r +: 256] === c)
				return 1'b1;
		return 1'b0;
	endfunction : rot_ok
	task automatic tally_and_finish;
		if (errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic guard(input int n);
		if (n >= 50)
		begin
			errors++;
			tally_and_finish();
		end
	endtask : guard
	// write: address and data offered together, each dropped once taken
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
		int n;
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge ref_clk_i);
		awv <= 1;
		awa <= a;
		wv <= 1;
		wd <= d;
		br <= 1;
		// ready is read at the edge itself, before the slave updates it
		for (n = 0; n < 50 && !(aw_done && w_done); n++)
		begin
			@(posedge ref_clk_i);
			if (!aw_done && awr)
			begin
				aw_done = 1'b1;
				awv <= 0;
			end
			if (!w_done && wr)
			begin
				w_done = 1'b1;
				wv <= 0;
			end
		end
		guard(n);
		for (n = 0; n < 50 && bv !== 1'b1; n++)
			@(posedge ref_clk_i);
		guard(n);
		br <= 0;
		chk({30'h0, bresp}, {30'h0, AXI_OKAY});
	endtask : axi_write
	task automatic axi_read(input logic [3:0] a);
		int n;
		logic ar_done;
		ar_done = 1'b0;
		@(posedge ref_clk_i);
		arv <= 1;
		ara <= a;
		rr <= 1;
		for (n = 0; n < 50 && !ar_done; n++)
		begin
			@(posedge ref_clk_i);
			if (arr)
			begin
				ar_done = 1'b1;
				arv <= 0;
			end
		end
		guard(n);
		for (n = 0; n < 50 && rv !== 1'b1; n++)
			@(posedge ref_clk_i);
		guard(n);
		tmp = rd;
		rr <= 0;
	endtask : axi_read
	initial
	begin
		seed = 47198;
		{awv, wv, br, arv, rr, rfc, gfc, awa, ara, wd, psd, pbc, pfc, idx, errors, checked} = '0;
		rx_frame_i = '0;
		next_frame = '0;
		frame_start = 0;
		rst_n_i = 0;
		repeat (4) @(posedge ref_clk_i);
		rst_n_i <= 1;
		axi_read(CTRL_OFFSET);
		chk(tmp, 32'h0);
		axi_read(4'h8);
		chk({tmp[29:0], rresp}, {30'h0, AXI_SLVERR});
		// four one-hot codes under each clock source, then off and a two-hot code
		for (k = 0; k < 10; k++)
		begin
			code = (k < 8) ? (4'h1 << (k % 4)) : ((k == 8) ? 4'h0 : 4'h3);
			eff = (code == 4'h3) ? 4'h0 : code;
			csel = k[2];
			idx = k % 4;
			rnd = {$random(seed), $random(seed)};
			next_frame <= rnd[58:0];
			{psd, pbc, pfc, rfc} <= rnd[63:51];
			gfc <= ~rnd[51];
			axi_write(CTRL_OFFSET, {rnd[31:5], csel, code});
			axi_read(CTRL_OFFSET);
			chk(tmp, {27'h0, csel, code});
			repeat (700) @(posedge ref_clk_i);
			axi_read(STATUS_OFFSET);
			chk(tmp, {28'h0, eff});
			chk({28'h0, fco}, {28'h0, (eff & {4{csel ? gfc : rfc}}) | (~eff & pfc)});
			chk({24'h0, (sdo & ~eff), (bco & ~eff)}, {24'h0, (psd & ~eff), (pbc & ~eff)});
			if (eff != 4'h0)
				chk({31'h0, rot_ok(cap, frame_bits(rx_frame_i))}, 32'h1);
		end
		tally_and_finish();
	end
endmodule : testbench
